// [src/frtoc_top.sv]
// Free-running 16-bit timer, coherent counter read, two output compares.
// Assumes an APB master on pclk; byte registers sit in the low data bits.
// How it works
// - Counter advances once per four bus clocks via fixed prescaler.
// - Counter steps on its own schedule; reads never alter it.
// - Counter readable at primary and alternate register pairs.
// - Low-byte read without prior high read returns live low byte.
// - High read latches low byte; repeats keep buffer until low read.
// - Low read after a high read returns the buffered low byte.
// - Primary high read can help clear overflow; alternate never does.
// - Compare bytes freely read and written; hardware never alters them.
// - Channel one compare: high byte at lower, low at next address.
// - Channel two compare: high byte at lower, low at next address.
// - On tick equality set match flag and drive level to pin.
// - High compare byte write suspends compares until low write.
// - Low-only compare write leaves compares running.
// - Writing one compare byte leaves the other byte unchanged.
// - Level bit goes to pin latch whether flag set or clear.
// - Match with interrupt enable set raises interrupt request.
// - Match flags and compare bytes untouched by reset.
// - Both channels may drive one pin for short pulses.
// - Compare irq enables live in control one, reset to zero.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module frtoc_top
  import frtoc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             compare_pin_one,
  output logic             compare_pin_two,
  output logic             timer_irq
);
  logic [1:0]  pre_reg;
  logic        tick;
  logic [15:0] count_reg;
  logic [7:0]  rd_buf_reg;
  logic        buf_hold_reg;
  logic [7:0]  cmp_hi_reg [FRTOC_NCH];
  logic [7:0]  cmp_lo_reg [FRTOC_NCH];
  logic [FRTOC_NCH-1:0] inhibit_reg;
  logic [FRTOC_NCH-1:0] match_flag_reg;
  logic [FRTOC_NCH-1:0] flag_armed_reg;
  logic [FRTOC_NCH-1:0] hit;
  logic        overflow_flag_reg;
  logic        ovf_armed_reg;
  logic [7:0]  ctrl1_reg;
  logic [7:0]  ctrl2_reg;
  logic        access;
  logic        wr;
  logic        rd;
  logic        addr_ok;
  logic [7:0]  idx;
  logic        setup_rd;
  logic        setup_rd_hi;
  logic        rd_cnt_hi;
  logic        rd_cnt_lo;
  logic        rd_status;
  logic        wr_lo_byte;
  logic [7:0]  rdata_next;
  logic [FRTOC_NCH-1:0] pin_level;
  logic [FRTOC_NCH-1:0] irq_en;
  logic        link;
  logic        pin_one_next;
  logic        pin_two_next;

  // APB decode: zero-wait slave, answers in the access cycle
  assign access = psel & penable;
  assign wr     = access & pwrite & addr_ok;
  assign rd     = access & ~pwrite & addr_ok;
  assign idx    = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'h0) & (paddr[11:10] == 2'h0) &
                   (idx == FRTOC_IDX_CMP1_HI || idx == FRTOC_IDX_CMP1_LO ||
                    idx == FRTOC_IDX_CMP2_HI || idx == FRTOC_IDX_CMP2_LO ||
                    (idx >= FRTOC_IDX_CNT_HI && idx <= FRTOC_IDX_STATUS));
  assign wr_lo_byte = wr & pstrb[0];
  // Read data is sampled in the setup cycle, so the buffer latches there too
  assign setup_rd    = psel & ~penable & ~pwrite & addr_ok;
  assign setup_rd_hi = setup_rd &
                       (idx == FRTOC_IDX_CNT_HI || idx == FRTOC_IDX_ALT_HI);
  assign rd_cnt_hi = rd & (idx == FRTOC_IDX_CNT_HI || idx == FRTOC_IDX_ALT_HI);
  assign rd_cnt_lo = rd & (idx == FRTOC_IDX_CNT_LO || idx == FRTOC_IDX_ALT_LO);
  assign rd_status = rd & (idx == FRTOC_IDX_STATUS);

  assign irq_en[0]    = ctrl1_reg[FRTOC_CTRL1_IE1_BIT];
  assign irq_en[1]    = ctrl1_reg[FRTOC_CTRL1_IE2_BIT];
  assign pin_level[0] = ctrl2_reg[FRTOC_CTRL2_LVL1_BIT];
  assign pin_level[1] = ctrl2_reg[FRTOC_CTRL2_LVL2_BIT];
  assign link         = ctrl2_reg[FRTOC_CTRL2_LINK_BIT];

  // Prescaler: the tick is one bus cycle in four
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg <= 2'h0;
    end else begin
      pre_reg <= pre_reg + 2'h1;
    end
  end
  assign tick = (pre_reg == FRTOC_PRE_LAST);

  // Counter ignores bus traffic entirely
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= FRTOC_CNT_RESET;
    end else if (tick) begin
      count_reg <= count_reg + 16'h0001;
    end
  end

  // Coherent read buffer for the low byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_buf_reg   <= 8'h00;
      buf_hold_reg <= 1'b0;
    end else if (setup_rd_hi && !buf_hold_reg) begin
      rd_buf_reg   <= count_reg[7:0];
      buf_hold_reg <= 1'b1;
    end else if (addr_ok && rd_cnt_lo) begin
      buf_hold_reg <= 1'b0;
    end
  end

  // Overflow flag: set on wrap, cleared by status read then primary high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      overflow_flag_reg <= 1'b0;
      ovf_armed_reg     <= 1'b0;
    end else begin
      if (tick && count_reg == FRTOC_CNT_MAX) begin
        overflow_flag_reg <= 1'b1;
        ovf_armed_reg     <= 1'b0;
      end else if (rd && idx == FRTOC_IDX_CNT_HI && ovf_armed_reg) begin
        overflow_flag_reg <= 1'b0;
        ovf_armed_reg     <= 1'b0;
      end else if (rd_status && overflow_flag_reg) begin
        ovf_armed_reg <= 1'b1;
      end
    end
  end

  // Control registers (reset to zero)
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl1_reg <= FRTOC_CTRL1_RESET;
      ctrl2_reg <= FRTOC_CTRL2_RESET;
    end else if (wr_lo_byte && idx == FRTOC_IDX_CTRL1) begin
      ctrl1_reg <= pwdata[7:0];
    end else if (wr_lo_byte && idx == FRTOC_IDX_CTRL2) begin
      ctrl2_reg <= pwdata[7:0];
    end
  end

  // Compare channels; storage and flags deliberately not reset
  genvar ch;
  generate
    for (ch = 0; ch < FRTOC_NCH; ch++) begin : g_ch
      localparam logic [7:0] HI_IDX =
        (ch == 0) ? FRTOC_IDX_CMP1_HI : FRTOC_IDX_CMP2_HI;
      localparam logic [7:0] LO_IDX =
        (ch == 0) ? FRTOC_IDX_CMP1_LO : FRTOC_IDX_CMP2_LO;
      always_ff @(posedge pclk) begin
        if (wr_lo_byte && idx == HI_IDX) begin
          cmp_hi_reg[ch] <= pwdata[7:0];
        end
        if (wr_lo_byte && idx == LO_IDX) begin
          cmp_lo_reg[ch] <= pwdata[7:0];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          inhibit_reg[ch] <= 1'b0;
        end else if (wr_lo_byte && idx == HI_IDX) begin
          inhibit_reg[ch] <= 1'b1;
        end else if (wr_lo_byte && idx == LO_IDX) begin
          inhibit_reg[ch] <= 1'b0;
        end
      end

      assign hit[ch] = tick & ~inhibit_reg[ch] &
                       ({cmp_hi_reg[ch], cmp_lo_reg[ch]} == count_reg);

      // Flag clears by status read then low compare write; a hit wins
      always_ff @(posedge pclk) begin
        if (hit[ch]) begin
          match_flag_reg[ch] <= 1'b1;
          flag_armed_reg[ch] <= 1'b0;
        end else if (wr_lo_byte && idx == LO_IDX && flag_armed_reg[ch]) begin
          match_flag_reg[ch] <= 1'b0;
          flag_armed_reg[ch] <= 1'b0;
        end else if (rd_status && match_flag_reg[ch]) begin
          flag_armed_reg[ch] <= 1'b1;
        end
      end

      AST_HIT_SETS_FLAG: assert property (@(posedge pclk)
        disable iff (!presetn)
        hit[ch] |=> match_flag_reg[ch])
        else $error("match did not set its flag");
      AST_INHIBIT_BLOCKS: assert property (@(posedge pclk)
        disable iff (!presetn)
        inhibit_reg[ch] |-> !hit[ch])
        else $error("compare ran while inhibited");
      // Per-channel write effects on storage, on the inhibit and on the match flag
      AST_HI_WRITE_INHIBITS: assert property (@(posedge pclk)
        disable iff (!presetn)
        (wr_lo_byte && idx == HI_IDX) |=> inhibit_reg[ch])
        else $error("high compare write did not suspend compares");
      AST_LO_WRITE_RUNS: assert property (@(posedge pclk)
        disable iff (!presetn)
        (wr_lo_byte && idx == LO_IDX) |=> !inhibit_reg[ch])
        else $error("low compare write left compares suspended");
      AST_HI_WRITE_LANDS: assert property (@(posedge pclk)
        disable iff (!presetn)
        (wr_lo_byte && idx == HI_IDX) |=>
        cmp_hi_reg[ch] == $past(pwdata[7:0]))
        else $error("high compare byte not written");
      AST_LO_WRITE_LANDS: assert property (@(posedge pclk)
        disable iff (!presetn)
        (wr_lo_byte && idx == LO_IDX) |=>
        cmp_lo_reg[ch] == $past(pwdata[7:0]))
        else $error("low compare byte not written");
      AST_ARMED_CLEAR: assert property (@(posedge pclk)
        disable iff (!presetn)
        (wr_lo_byte && idx == LO_IDX && flag_armed_reg[ch] && !hit[ch]) |=>
        !match_flag_reg[ch])
        else $error("armed flag not cleared by low compare write");
    end
  endgenerate

  // With link set, channel two also clocks its level onto pin one
  always_comb begin
    pin_one_next = compare_pin_one;
    pin_two_next = compare_pin_two;
    if (hit[0]) begin
      pin_one_next = pin_level[0];
    end
    if (hit[1]) begin
      pin_two_next = pin_level[1];
      if (link) begin
        pin_one_next = pin_level[1];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_pin_one <= 1'b0;
      compare_pin_two <= 1'b0;
    end else begin
      compare_pin_one <= pin_one_next;
      compare_pin_two <= pin_two_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq <= 1'b0;
    end else begin
      timer_irq <= |(match_flag_reg & irq_en);
    end
  end

  // Read mux
  always_comb begin
    rdata_next = 8'h00;
    case (idx)
      FRTOC_IDX_CMP1_HI: rdata_next = cmp_hi_reg[0];
      FRTOC_IDX_CMP1_LO: rdata_next = cmp_lo_reg[0];
      FRTOC_IDX_CMP2_HI: rdata_next = cmp_hi_reg[1];
      FRTOC_IDX_CMP2_LO: rdata_next = cmp_lo_reg[1];
      FRTOC_IDX_CNT_HI,
      FRTOC_IDX_ALT_HI:  rdata_next = count_reg[15:8];
      FRTOC_IDX_CNT_LO,
      FRTOC_IDX_ALT_LO:  rdata_next = buf_hold_reg ? rd_buf_reg
                                      : count_reg[7:0];
      FRTOC_IDX_CTRL1:   rdata_next = ctrl1_reg;
      FRTOC_IDX_CTRL2:   rdata_next = ctrl2_reg;
      FRTOC_IDX_STATUS: begin
        rdata_next[FRTOC_STAT_MF1_BIT] = match_flag_reg[0];
        rdata_next[FRTOC_STAT_MF2_BIT] = match_flag_reg[1];
        rdata_next[FRTOC_STAT_OVF_BIT] = overflow_flag_reg;
      end
      default:           rdata_next = 8'h00;
    endcase
  end

  // Data is registered in the setup cycle, so it is valid in the access one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata  <= {24'h00_0000, addr_ok ? rdata_next : 8'h00};
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~addr_ok;
    end
  end

  AST_LOW_READ_RELEASES: assert property (@(posedge pclk)
    disable iff (!presetn)
    (addr_ok && rd_cnt_lo && !rd_cnt_hi) |=> !buf_hold_reg)
    else $error("buffer not released after low read");
  AST_BUF_FROZEN: assert property (@(posedge pclk)
    disable iff (!presetn)
    buf_hold_reg && !rd_cnt_lo |=> $stable(rd_buf_reg))
    else $error("held buffer changed");
  AST_COUNT_STEP: assert property (@(posedge pclk)
    disable iff (!presetn)
    !tick |=> $stable(count_reg))
    else $error("counter moved off the tick");
  AST_TICK_SPACING: assert property (@(posedge pclk)
    disable iff (!presetn)
    tick |=> !tick ##1 !tick ##1 !tick ##1 tick)
    else $error("tick not every four cycles");
  AST_ALT_NO_OVF: assert property (@(posedge pclk)
    disable iff (!presetn)
    (rd && idx == FRTOC_IDX_ALT_HI && overflow_flag_reg) |=>
    overflow_flag_reg)
    else $error("alternate read cleared overflow");
  AST_CTRL_RESET: assert property (@(posedge pclk)
    $rose(presetn) |-> ctrl1_reg == FRTOC_CTRL1_RESET)
    else $error("control one not zero after reset");
  AST_TICK_ADVANCES: assert property (@(posedge pclk)
    disable iff (!presetn)
    tick |=> count_reg == $past(count_reg) + 16'h0001)
    else $error("counter did not step on the tick");

  // Coherent read path: high byte, latch, live and held low byte
  AST_HIGH_READ_LATCHES: assert property (@(posedge pclk)
    disable iff (!presetn)
    (setup_rd_hi && !buf_hold_reg) |=>
    buf_hold_reg && rd_buf_reg == $past(count_reg[7:0]))
    else $error("high read did not latch the low byte");
  AST_HIGH_READ_VALUE: assert property (@(posedge pclk)
    disable iff (!presetn)
    setup_rd_hi |=> prdata[7:0] == $past(count_reg[15:8]))
    else $error("high counter byte read wrong");
  AST_LIVE_LOW: assert property (@(posedge pclk)
    disable iff (!presetn)
    (setup_rd && !buf_hold_reg &&
     (idx == FRTOC_IDX_CNT_LO || idx == FRTOC_IDX_ALT_LO)) |=>
    prdata[7:0] == $past(count_reg[7:0]))
    else $error("lone low read not live");
  AST_HELD_LOW: assert property (@(posedge pclk)
    disable iff (!presetn)
    (setup_rd && buf_hold_reg &&
     (idx == FRTOC_IDX_CNT_LO || idx == FRTOC_IDX_ALT_LO)) |=>
    prdata[7:0] == $past(rd_buf_reg))
    else $error("low read after high read not buffered");

  // Compare pins follow the level bits only on a match; the request follows the enabled match flags
  AST_PIN_ONE_LEVEL: assert property (@(posedge pclk)
    disable iff (!presetn)
    (hit[0] && !(hit[1] && link)) |=>
    compare_pin_one == $past(pin_level[0]))
    else $error("pin one did not take its level");
  AST_PIN_TWO_LEVEL: assert property (@(posedge pclk)
    disable iff (!presetn)
    hit[1] |=> compare_pin_two == $past(pin_level[1]))
    else $error("pin two did not take its level");
  AST_LINK_PIN: assert property (@(posedge pclk)
    disable iff (!presetn)
    (hit[1] && link) |=> compare_pin_one == $past(pin_level[1]))
    else $error("linked match did not drive pin one");
  AST_PINS_HOLD: assert property (@(posedge pclk)
    disable iff (!presetn)
    (!hit[0] && !hit[1]) |=>
    $stable(compare_pin_one) && $stable(compare_pin_two))
    else $error("compare pin moved without a match");
  AST_IRQ_RAISED: assert property (@(posedge pclk)
    disable iff (!presetn)
    (|(match_flag_reg & irq_en)) |=> timer_irq)
    else $error("enabled match flag raised no request");
  AST_IRQ_MASKED: assert property (@(posedge pclk)
    disable iff (!presetn)
    (irq_en == 2'h0) |=> !timer_irq)
    else $error("request raised with enables clear");
endmodule
`default_nettype wire

// [src/frtoc_pkg.sv]
// Package for the free-running timer with two output compare channels.
// Assumes a 32-bit APB slave with one byte register per aligned word.
package frtoc_pkg;
  // Printed register indices; byte address is four times the index
  localparam logic [7:0] FRTOC_IDX_CMP1_HI   = 8'h12;
  localparam logic [7:0] FRTOC_IDX_CMP1_LO   = 8'h13;
  localparam logic [7:0] FRTOC_IDX_CMP2_HI   = 8'h16;
  localparam logic [7:0] FRTOC_IDX_CMP2_LO   = 8'h17;
  localparam logic [7:0] FRTOC_IDX_CNT_HI    = 8'h18;
  localparam logic [7:0] FRTOC_IDX_CNT_LO    = 8'h19;
  localparam logic [7:0] FRTOC_IDX_ALT_HI    = 8'h1a;
  localparam logic [7:0] FRTOC_IDX_ALT_LO    = 8'h1b;
  localparam logic [7:0] FRTOC_IDX_CTRL1     = 8'h1c;
  localparam logic [7:0] FRTOC_IDX_CTRL2     = 8'h1d;
  localparam logic [7:0] FRTOC_IDX_STATUS    = 8'h1e;
  // Control register one fields
  localparam int FRTOC_CTRL1_IE1_BIT = 5;
  localparam int FRTOC_CTRL1_IE2_BIT = 3;
  localparam logic [7:0] FRTOC_CTRL1_RESET = 8'h00;
  // Control register two fields
  localparam int FRTOC_CTRL2_LVL1_BIT = 0;
  localparam int FRTOC_CTRL2_LVL2_BIT = 1;
  localparam int FRTOC_CTRL2_LINK_BIT = 2;
  localparam logic [7:0] FRTOC_CTRL2_RESET = 8'h00;
  // Status register fields
  localparam int FRTOC_STAT_MF1_BIT = 5;
  localparam int FRTOC_STAT_MF2_BIT = 3;
  localparam int FRTOC_STAT_OVF_BIT = 7;
  // Prescaler, counter limits and channel count
  localparam int FRTOC_PRESCALE = 4;
  localparam logic [1:0] FRTOC_PRE_LAST = 2'h3;
  localparam logic [15:0] FRTOC_CNT_RESET = 16'h0000;
  localparam logic [15:0] FRTOC_CNT_MAX   = 16'hffff;
  localparam int FRTOC_NCH = 2;
endpackage

// [sim/frtoc_cpu_model.sv]
// Processor-side APB master model that talks to the timer registers.
// Assumes one pclk domain; the bench top calls xfer by hierarchy.
`timescale 1ns/10ps
`default_nettype none
module frtoc_cpu_model (
  input  wire logic        pclk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [11:0] paddr,
  output logic      [31:0] pwdata,
  output logic      [3:0]  pstrb
);
  initial begin
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end

  // Byte registers sit in lane 0, so only that strobe is used on writes
  task automatic xfer(input logic w, input logic [7:0] idx,
                      input logic [7:0] wd, output logic [31:0] rd,
                      output logic err);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {2'h0, idx, 2'h0};
    pwdata <= {24'h0, wd};
    pstrb  <= {3'h0, w};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released lines must not keep showing the last request
    paddr  <= ~paddr;
    pwdata <= ~pwdata;
  endtask
endmodule
`default_nettype wire

// [sim/free_running_timer_output_compare_tb_top.sv]
// Self-checking bench for the free-running timer with two compares.
// Assumes the processor model drives APB; pclk runs at 50 MHz.
`timescale 1ns/10ps
`default_nettype none
`define CHK(what, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("ERROR %s expected %h seen %h", what, exp, got); \
  end \
end
module free_running_timer_output_compare_tb_top
  import frtoc_pkg::*;
;
  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        compare_pin_one;
  logic        compare_pin_two;
  logic        timer_irq;
  logic [31:0] rdat;
  logic        rerr;
  logic [15:0] cnt;
  logic [15:0] tgt;
  logic [7:0]  buf_lo;
  int          n_mismatch = 0;
  int          comparisons = 0;

  always #10 pclk = ~pclk;

  frtoc_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .compare_pin_one,
    .compare_pin_two, .timer_irq);
  frtoc_cpu_model i_cpu (.pclk, .prdata, .pready, .pslverr, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb);

  task automatic rd(input logic [7:0] idx);
    i_cpu.xfer(1'b0, idx, 8'h00, rdat, rerr);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    i_cpu.xfer(1'b1, idx, d, rdat, rerr);
  endtask
  // High byte first, then low byte, so the pair is one coherent count
  task automatic rd_cnt(input logic [7:0] hi_idx);
    rd(hi_idx);
    cnt[15:8] = rdat[7:0];
    rd(hi_idx + 8'h01);
    cnt[7:0] = rdat[7:0];
  endtask
  task automatic wait_pins(input logic [1:0] want);
    int n;
    n = 0;
    while ({compare_pin_two, compare_pin_one} !== want && n < 120) begin
      @(posedge pclk);
      n++;
    end
    `CHK("compare pins", want, {compare_pin_two, compare_pin_one})
  endtask
  // Counter stays below 256 counts here, so only the low byte moves
  task automatic lo_match(input logic [7:0] lvl, input logic [7:0] lo_idx,
                          input logic [1:0] want);
    wr(FRTOC_IDX_CTRL2, lvl);
    rd_cnt(FRTOC_IDX_CNT_HI);
    tgt = cnt + 16'd12;
    wr(lo_idx, tgt[7:0]);
    wait_pins(want);
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(FRTOC_IDX_CTRL1);
    `CHK("ctrl one reset", 32'h0, rdat)
    rd(8'h00);
    `CHK("unmapped error", 1'b1, rerr)
    `CHK("unmapped data", 32'h0, rdat)
    wr(FRTOC_IDX_CMP2_HI, 8'hff);
    wr(FRTOC_IDX_CMP2_LO, 8'h00);
    wr(FRTOC_IDX_CTRL1, 8'h28);
    wr(FRTOC_IDX_CTRL2, 8'h03);
    rd(FRTOC_IDX_CMP2_HI);
    `CHK("compare two high", 32'hff, rdat)
    rd_cnt(FRTOC_IDX_CNT_HI);
    tgt = cnt + 16'd16;
    wr(FRTOC_IDX_CMP1_HI, tgt[15:8]);
    rd(FRTOC_IDX_STATUS);
    wr(FRTOC_IDX_CMP1_LO, tgt[7:0]);
    wait_pins(2'b01);
    rd(FRTOC_IDX_STATUS);
    `CHK("flag one", 1'b1, rdat[FRTOC_STAT_MF1_BIT])
    `CHK("irq", 1'b1, timer_irq)
    rd_cnt(FRTOC_IDX_CNT_HI);
    tgt = cnt + 16'd12;
    wr(FRTOC_IDX_CMP2_LO, tgt[7:0]);
    wr(FRTOC_IDX_CMP2_HI, tgt[15:8]);
    repeat (80) @(posedge pclk);
    `CHK("pin two held", 1'b0, compare_pin_two)
    lo_match(8'h03, FRTOC_IDX_CMP2_LO, 2'b11);
    rd(FRTOC_IDX_STATUS);
    `CHK("flag two", 1'b1, rdat[FRTOC_STAT_MF2_BIT])
    lo_match(8'h02, FRTOC_IDX_CMP1_LO, 2'b10);
    lo_match(8'h03, FRTOC_IDX_CMP1_LO, 2'b11);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    `CHK("pins after reset", 2'b00, {compare_pin_two, compare_pin_one})
    rd(FRTOC_IDX_CTRL1);
    `CHK("ctrl one after reset", 32'h0, rdat)
    rd(FRTOC_IDX_CMP1_LO);
    `CHK("compare one low kept", {24'h0, tgt[7:0]}, rdat)
    wr(FRTOC_IDX_CMP1_HI, 8'h5a);
    rd(FRTOC_IDX_CMP1_LO);
    `CHK("compare one low alone", {24'h0, tgt[7:0]}, rdat)
    rd(FRTOC_IDX_CMP1_HI);
    `CHK("compare one high", 32'h5a, rdat)
    rd_cnt(FRTOC_IDX_CNT_HI);
    tgt = cnt;
    repeat (2) @(posedge pclk);
    rd_cnt(FRTOC_IDX_ALT_HI);
    `CHK("count step", 16'd2, cnt - tgt)
    rd(FRTOC_IDX_ALT_HI);
    @(posedge pclk);
    rd(FRTOC_IDX_ALT_HI);
    rd(FRTOC_IDX_ALT_LO);
    buf_lo = rdat[7:0];
    repeat (2) @(posedge pclk);
    rd(FRTOC_IDX_ALT_LO);
    `CHK("live low minus held low", 8'h03, rdat[7:0] - buf_lo)
    wr(FRTOC_IDX_CMP2_HI, 8'h00);
    lo_match(8'h06, FRTOC_IDX_CMP2_LO, 2'b11);
    tally_and_finish();
  end
endmodule
`default_nettype wire
